// ---- core/counter_array_pkg.sv ----
package counter_array_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] OFS_COUNT_LOW  = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFS_ARRAY_MODE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  // module n sits at 0x20 + 0x10*n, with three words each
  localparam logic [3:0] MOD_BASE_NIB   = 4'h2;
  localparam logic [3:0] OFS_MOD_CTRL   = 4'h0;
  localparam logic [3:0] OFS_MOD_CMP_LO = 4'h4;
  localparam logic [3:0] OFS_MOD_CMP_HI = 4'h8;

  // array_mode_reg fields
  localparam int MD_IDLE_STOP = 7;
  localparam int MD_WATCHDOG  = 6;
  localparam int MD_RUN       = 5;
  localparam int MD_OVF_FLAG  = 4;
  localparam int MD_TB_HI     = 3;
  localparam int MD_TB_LO     = 1;
  localparam int MD_OVF_IE    = 0;
  localparam logic [7:0] MODE_RESET = 8'h40;

  // module control fields
  localparam int MC_PWM16 = 7;
  localparam int MC_ECOM  = 6;
  localparam int MC_CAPP  = 5;
  localparam int MC_CAPN  = 4;
  localparam int MC_MAT   = 3;
  localparam int MC_TOG   = 2;
  localparam int MC_PWM   = 1;
  localparam int MC_ECCF  = 0;

  // interrupt enable register fields
  localparam int IE_GLOBAL = 7;
  localparam int IE_ARRAY  = 0;

  // interrupt status layout: overflow then one bit per module
  localparam int NUM_MODULES  = 3;
  localparam int WDT_MODULE   = 2;
  localparam int NUM_EVENTS   = 4;
  localparam int ST_OVERFLOW  = 0;
  localparam int ST_MOD_FIRST = 1;

  // synchroniser lanes
  localparam int NUM_SYNC  = 5;
  localparam int SY_EXT    = 0;
  localparam int SY_XOSC   = 1;
  localparam int SY_IO_LO  = 2;

  // prescaler counts
  localparam int DIV12 = 12;
  localparam int DIV4  = 4;
  localparam logic [3:0] DIV12_LAST = 4'(DIV12 - 1);
  localparam logic [1:0] DIV4_LAST  = 2'(DIV4 - 1);

  typedef enum logic [2:0] {
    TB_DIV12    = 3'h0,
    TB_DIV4     = 3'h1,
    TB_T0_OVF   = 3'h2,
    TB_EXT_FALL = 3'h3,
    TB_SYS      = 3'h4,
    TB_XOSC8    = 3'h5
  } timebase_t;

endpackage

// ---- core/edge_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_sync3 (
  // clock, reset, enable
  input  wire logic                                  clk_in,
  input  wire logic                                  rst_b_in,
  input  wire logic                                  ce_in,
  // asynchronous lanes
  input  wire logic [counter_array_pkg::NUM_SYNC-1:0] async_in,
  // filtered level and one-cycle edges
  output logic      [counter_array_pkg::NUM_SYNC-1:0] level_out,
  output logic      [counter_array_pkg::NUM_SYNC-1:0] rise_out,
  output logic      [counter_array_pkg::NUM_SYNC-1:0] fall_out
);
  import counter_array_pkg::*;

  typedef struct packed {
    logic [NUM_SYNC-1:0] s1;
    logic [NUM_SYNC-1:0] s2;
    logic [NUM_SYNC-1:0] s3;
    logic [NUM_SYNC-1:0] stable;
  } sync_t;

  sync_t cur;
  sync_t next_cur;
  logic [NUM_SYNC-1:0] agree;

  //////////////////////////////////////////////////////////////////////////
  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb begin
    agree           = ~(cur.s2 ^ cur.s3);
    next_cur        = cur;
    next_cur.s1     = async_in;
    next_cur.s2     = cur.s1;
    next_cur.s3     = cur.s2;
    next_cur.stable = (agree & cur.s3) | (~agree & cur.stable);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cur <= '0;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  assign level_out = cur.stable;
  assign rise_out  = agree & cur.s3 & ~cur.stable;
  assign fall_out  = agree & ~cur.s3 & cur.stable;

endmodule
`default_nettype wire

// ---- core/counter_array_timebase.sv ----
// Overview of operation
// - count built from high and low bytes
// - low read snapshots high; high read returns it
// - count reads never disturb counting
// - wrap from FFFF to 0 sets overflow flag
// - overflow requests interrupt only when enabled
// - only a software write clears overflow flag
// - interrupt needs global and array enables
// - idle stop clear keeps counting during idle
// - three-bit select picks one of six timebases
// - external input counts falling edges, max sysclk/4
// - external oscillator divided input is synchronised
// - three compare modules share counter, own lines
// - each module takes one of six modes
// - module 2 watchdog after reset restricts writes
`timescale 1ns/1ps
`default_nettype none
module counter_array_timebase (
  // clock, reset, enable
  input  wire logic                                     SYS_CLK_IN,
  input  wire logic                                     RST_B_IN,
  input  wire logic                                     CE_IN,
  // processor state and timebase sources
  input  wire logic                                     IDLE_IN,
  input  wire logic                                     T0_OVF_IN,
  input  wire logic                                     EXT_COUNT_IN,
  input  wire logic                                     XOSC_DIV8_IN,
  // module io lines
  input  wire logic [counter_array_pkg::NUM_MODULES-1:0] MODULE_IO_IN,
  output logic      [counter_array_pkg::NUM_MODULES-1:0] MODULE_IO_OUT,
  output logic      [counter_array_pkg::NUM_MODULES-1:0] MODULE_IO_OE_OUT,
  // apb slave
  input  wire logic                                     PSEL_IN,
  input  wire logic                                     PENABLE_IN,
  input  wire logic                                     PWRITE_IN,
  input  wire logic [counter_array_pkg::ADDR_W-1:0]      PADDR_IN,
  input  wire logic [counter_array_pkg::DATA_W-1:0]      PWDATA_IN,
  output logic      [counter_array_pkg::DATA_W-1:0]      PRDATA_OUT,
  output logic                                          PREADY_OUT,
  output logic                                          PSLVERR_OUT,
  // interrupt and watchdog
  output logic                                          IRQ_OUT,
  output logic                                          WATCHDOG_RST_OUT
);
  import counter_array_pkg::*;

  typedef struct packed {
    logic [15:0]                  count;
    logic [7:0]                   snapshot;
    logic                         idle_stop_ctrl;
    logic                         watchdog_mode;
    logic                         run;
    logic                         count_overflow_flag;
    timebase_t                    timebase_select;
    logic                         overflow_irq_enable;
    logic                         global_irq_enable;
    logic                         array_irq_enable;
    logic [NUM_EVENTS-1:0]        irq_status;
    logic [NUM_EVENTS-1:0]        irq_mask;
    logic [3:0]                   div12;
    logic [1:0]                   div4;
    logic [NUM_MODULES-1:0][7:0]  mod_ctl;
    logic [NUM_MODULES-1:0][15:0] mod_cmp;
    logic [NUM_MODULES-1:0]       io_level;
    logic                         watchdog_rst;
    logic                         rd_loaded;
    logic [DATA_W-1:0]            prdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic [NUM_SYNC-1:0] sync_level;
  logic [NUM_SYNC-1:0] sync_rise;
  logic [NUM_SYNC-1:0] sync_fall;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: external count, oscillator/8, module io lines

  edge_sync3 u_sync (
    .clk_in    (SYS_CLK_IN),
    .rst_b_in  (RST_B_IN),
    .ce_in     (CE_IN),
    .async_in  ({MODULE_IO_IN, XOSC_DIV8_IN, EXT_COUNT_IN}),
    .level_out (sync_level),
    .rise_out  (sync_rise),
    .fall_out  (sync_fall)
  );

  //////////////////////////////////////////////////////////////////////////
  // address decoding

  function automatic logic is_module(input logic [ADDR_W-1:0] a);
    logic sub_ok;
    sub_ok = (a[3:0] == OFS_MOD_CTRL) || (a[3:0] == OFS_MOD_CMP_LO) ||
             (a[3:0] == OFS_MOD_CMP_HI);
    return sub_ok && (a[7:4] >= MOD_BASE_NIB) &&
           (a[7:4] < MOD_BASE_NIB + 4'(NUM_MODULES));
  endfunction

  function automatic logic [1:0] mod_index(input logic [ADDR_W-1:0] a);
    return 2'(a[7:4] - MOD_BASE_NIB);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_COUNT_LOW) || (a == OFS_COUNT_HIGH) ||
           (a == OFS_ARRAY_MODE) || (a == OFS_IRQ_STATUS) ||
           (a == OFS_IRQ_MASK) || (a == OFS_IRQ_ENABLE) || is_module(a);
  endfunction

  function automatic logic [7:0] mode_byte(input state_t s);
    logic [7:0] m;
    m                      = 8'h00;
    m[MD_IDLE_STOP]        = s.idle_stop_ctrl;
    m[MD_WATCHDOG]         = s.watchdog_mode;
    m[MD_RUN]              = s.run;
    m[MD_OVF_FLAG]         = s.count_overflow_flag;
    m[MD_TB_HI:MD_TB_LO]   = s.timebase_select;
    m[MD_OVF_IE]           = s.overflow_irq_enable;
    return m;
  endfunction

  function automatic logic [DATA_W-1:0] read_word(
    input state_t            s,
    input logic [ADDR_W-1:0] a
  );
    logic [7:0]  b;
    logic [1:0]  i;
    i = mod_index(a);
    b = 8'h00;
    if (a == OFS_COUNT_LOW) begin
      b = s.count[7:0];
    end else if (a == OFS_COUNT_HIGH) begin
      b = s.snapshot;
    end else if (a == OFS_ARRAY_MODE) begin
      b = mode_byte(s);
    end else if (a == OFS_IRQ_STATUS) begin
      b = 8'(s.irq_status);
    end else if (a == OFS_IRQ_MASK) begin
      b = 8'(s.irq_mask);
    end else if (a == OFS_IRQ_ENABLE) begin
      b[IE_GLOBAL] = s.global_irq_enable;
      b[IE_ARRAY]  = s.array_irq_enable;
    end else if (is_module(a)) begin
      if (a[3:0] == OFS_MOD_CTRL) begin
        b = s.mod_ctl[i];
      end else if (a[3:0] == OFS_MOD_CMP_LO) begin
        b = s.mod_cmp[i][7:0];
      end else begin
        b = s.mod_cmp[i][15:8];
      end
    end
    return {24'h000000, b};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic                   tick;
  logic                   src;
  logic                   running;
  logic [15:0]            count_inc;
  logic                   wrap;
  logic                   access;
  logic                   wr;
  logic                   rd;
  logic [1:0]             widx;
  logic [NUM_EVENTS-1:0]  events;
  logic [NUM_EVENTS-1:0]  rd_clear;
  logic [NUM_EVENTS-1:0]  irq_src_en;

  always_comb begin
    next_cur   = cur;
    events     = '0;
    rd_clear   = '0;
    src        = 1'b0;
    access     = PSEL_IN & PENABLE_IN & PREADY_OUT;
    wr         = access & PWRITE_IN;
    rd         = access & ~PWRITE_IN;
    widx       = mod_index(PADDR_IN);

    // prescalers run free so the divided ticks keep their phase
    next_cur.div12 = (cur.div12 == DIV12_LAST) ? 4'h0 : cur.div12 + 4'h1;
    next_cur.div4  = (cur.div4 == DIV4_LAST) ? 2'h0 : cur.div4 + 2'h1;

    unique case (cur.timebase_select)
      TB_DIV12:    src = (cur.div12 == DIV12_LAST);
      TB_DIV4:     src = (cur.div4 == DIV4_LAST);
      TB_T0_OVF:   src = T0_OVF_IN;
      // edges faster than sysclk/4 are not resolved here
      TB_EXT_FALL: src = sync_fall[SY_EXT];
      TB_SYS:      src = 1'b1;
      TB_XOSC8:    src = sync_rise[SY_XOSC];
      default:     src = 1'b0;
    endcase

    // watchdog keeps the counter alive even with run clear
    running   = (cur.run | cur.watchdog_mode) &
                ~(cur.idle_stop_ctrl & IDLE_IN);
    tick      = running & src;
    count_inc = cur.count + 16'h0001;
    wrap      = tick & (cur.count == 16'hFFFF);
    if (tick) begin
      next_cur.count = count_inc;
    end
    if (wrap) begin
      events[ST_OVERFLOW] = 1'b1;
    end

    next_cur.watchdog_rst = cur.watchdog_mode & tick &
                            (count_inc == cur.mod_cmp[WDT_MODULE]);

    for (int i = 0; i < NUM_MODULES; i++) begin
      if (!(cur.watchdog_mode && i == WDT_MODULE)) begin
        if (!cur.mod_ctl[i][MC_MAT] && !cur.mod_ctl[i][MC_TOG] &&
            !cur.mod_ctl[i][MC_PWM]) begin
          if ((cur.mod_ctl[i][MC_CAPP] && sync_rise[SY_IO_LO + i]) ||
              (cur.mod_ctl[i][MC_CAPN] && sync_fall[SY_IO_LO + i])) begin
            next_cur.mod_cmp[i]            = cur.count;
            events[ST_MOD_FIRST + i]       = 1'b1;
          end
        end else if (cur.mod_ctl[i][MC_ECOM] && tick) begin
          if (cur.mod_ctl[i][MC_PWM] && cur.mod_ctl[i][MC_TOG]) begin
            // frequency output: toggle and step the low compare
            if (count_inc[7:0] == cur.mod_cmp[i][7:0]) begin
              next_cur.io_level[i]       = ~cur.io_level[i];
              next_cur.mod_cmp[i][7:0]   = cur.mod_cmp[i][7:0] +
                                           cur.mod_cmp[i][15:8];
            end
          end else if (cur.mod_ctl[i][MC_PWM] &&
                       cur.mod_ctl[i][MC_PWM16]) begin
            if (count_inc == 16'h0000) begin
              next_cur.io_level[i] = 1'b0;
            end else if (count_inc == cur.mod_cmp[i]) begin
              next_cur.io_level[i] = 1'b1;
            end
          end else if (cur.mod_ctl[i][MC_PWM]) begin
            // 8-bit pwm reloads its duty from the high byte each period
            if (count_inc[7:0] == 8'h00) begin
              next_cur.io_level[i]     = 1'b0;
              next_cur.mod_cmp[i][7:0] = cur.mod_cmp[i][15:8];
            end else if (count_inc[7:0] == cur.mod_cmp[i][7:0]) begin
              next_cur.io_level[i]     = 1'b1;
            end
          end else if (cur.mod_ctl[i][MC_MAT] &&
                       count_inc == cur.mod_cmp[i]) begin
            events[ST_MOD_FIRST + i] = 1'b1;
            if (cur.mod_ctl[i][MC_TOG]) begin
              next_cur.io_level[i] = ~cur.io_level[i];
            end
          end
        end
      end
    end

    // read data is loaded a cycle ahead so it comes from flip-flops
    if (PSEL_IN && !PWRITE_IN && !cur.rd_loaded) begin
      next_cur.prdata    = read_word(cur, PADDR_IN);
      next_cur.rd_loaded = 1'b1;
      if (PADDR_IN == OFS_COUNT_LOW) begin
        // latch with the low byte so a carry in between cannot tear
        next_cur.snapshot = cur.count[15:8];
      end
    end
    if (access) begin
      next_cur.rd_loaded = 1'b0;
    end

    if (rd && PADDR_IN == OFS_IRQ_STATUS) begin
      // clear only what the reader saw so a late event survives
      rd_clear = cur.prdata[NUM_EVENTS-1:0];
    end

    if (wr) begin
      if (PADDR_IN == OFS_COUNT_LOW && !cur.watchdog_mode) begin
        next_cur.count[7:0] = PWDATA_IN[7:0];
      end else if (PADDR_IN == OFS_COUNT_HIGH && !cur.watchdog_mode) begin
        next_cur.count[15:8] = PWDATA_IN[7:0];
      end else if (PADDR_IN == OFS_ARRAY_MODE) begin
        next_cur.watchdog_mode = PWDATA_IN[MD_WATCHDOG];
        if (!cur.watchdog_mode) begin
          next_cur.idle_stop_ctrl      = PWDATA_IN[MD_IDLE_STOP];
          next_cur.run                 = PWDATA_IN[MD_RUN];
          next_cur.count_overflow_flag = PWDATA_IN[MD_OVF_FLAG];
          next_cur.timebase_select     =
            timebase_t'(PWDATA_IN[MD_TB_HI:MD_TB_LO]);
          next_cur.overflow_irq_enable = PWDATA_IN[MD_OVF_IE];
        end
      end else if (PADDR_IN == OFS_IRQ_MASK) begin
        next_cur.irq_mask = PWDATA_IN[NUM_EVENTS-1:0];
      end else if (PADDR_IN == OFS_IRQ_ENABLE) begin
        next_cur.global_irq_enable = PWDATA_IN[IE_GLOBAL];
        next_cur.array_irq_enable  = PWDATA_IN[IE_ARRAY];
      end else if (is_module(PADDR_IN)) begin
        if (cur.watchdog_mode && widx == 2'(WDT_MODULE)) begin
          // high-byte write services the watchdog
          if (PADDR_IN[3:0] == OFS_MOD_CMP_HI) begin
            next_cur.mod_cmp[WDT_MODULE] =
              {cur.count[15:8] + PWDATA_IN[7:0], cur.count[7:0]};
          end
        end else if (PADDR_IN[3:0] == OFS_MOD_CTRL) begin
          next_cur.mod_ctl[widx] = PWDATA_IN[7:0];
        end else if (PADDR_IN[3:0] == OFS_MOD_CMP_LO) begin
          next_cur.mod_cmp[widx][7:0]     = PWDATA_IN[7:0];
          next_cur.mod_ctl[widx][MC_ECOM] = 1'b0;
        end else begin
          next_cur.mod_cmp[widx][15:8]    = PWDATA_IN[7:0];
          next_cur.mod_ctl[widx][MC_ECOM] = 1'b1;
        end
      end
    end

    // hardware set wins over a clearing write or read
    if (events[ST_OVERFLOW]) begin
      next_cur.count_overflow_flag = 1'b1;
    end
    next_cur.irq_status = (cur.irq_status & ~rd_clear) | events;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      cur               <= '0;
      cur.watchdog_mode <= MODE_RESET[MD_WATCHDOG];
    end else if (CE_IN) begin
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    irq_src_en = cur.irq_mask;
    irq_src_en[ST_OVERFLOW] = cur.irq_mask[ST_OVERFLOW] &
                              cur.overflow_irq_enable;
    for (int i = 0; i < NUM_MODULES; i++) begin
      irq_src_en[ST_MOD_FIRST + i] = cur.irq_mask[ST_MOD_FIRST + i] &
                                     cur.mod_ctl[i][MC_ECCF];
    end
  end

  assign IRQ_OUT = cur.global_irq_enable & cur.array_irq_enable &
                   |(cur.irq_status & irq_src_en);

  // writes finish at once; reads wait for the loaded word
  assign PREADY_OUT  = CE_IN & (PWRITE_IN | cur.rd_loaded);
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & PREADY_OUT &
                       ~is_mapped(PADDR_IN);
  assign PRDATA_OUT  = cur.prdata;

  assign WATCHDOG_RST_OUT = cur.watchdog_rst;
  assign MODULE_IO_OUT    = cur.io_level;

  always_comb begin
    for (int i = 0; i < NUM_MODULES; i++) begin
      MODULE_IO_OE_OUT[i] = cur.mod_ctl[i][MC_ECOM] &
                            (cur.mod_ctl[i][MC_TOG] | cur.mod_ctl[i][MC_PWM]) &
                            ~(cur.watchdog_mode && i == WDT_MODULE);
    end
  end

endmodule
`default_nettype wire

// ---- bench/counter_array_timebase_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module counter_array_timebase_properties
  import counter_array_pkg::*;
(
  // clock, reset, enable
  input wire logic                                      SYS_CLK_IN,
  input wire logic                                      RST_B_IN,
  input wire logic                                      CE_IN,
  // apb slave
  input wire logic                                      PSEL_IN,
  input wire logic                                      PENABLE_IN,
  input wire logic                                      PWRITE_IN,
  input wire logic [counter_array_pkg::ADDR_W-1:0]      PADDR_IN,
  input wire logic [counter_array_pkg::DATA_W-1:0]      PWDATA_IN,
  input wire logic [counter_array_pkg::DATA_W-1:0]      PRDATA_OUT,
  input wire logic                                      PREADY_OUT,
  input wire logic                                      PSLVERR_OUT,
  // interrupt and module lines
  input wire logic                                      IRQ_OUT,
  input wire logic [counter_array_pkg::NUM_MODULES-1:0] MODULE_IO_OE_OUT,
  input wire logic                                      WATCHDOG_RST_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    PSEL_IN && !PENABLE_IN && CE_IN;
  endsequence
  sequence s_wr_done;
    PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_read_nowait: assert property (s_setup ##1 PSEL_IN && PENABLE_IN
    |-> PREADY_OUT) else $error("access cycle not ready");
  chk_write_ready: assert property (PSEL_IN && PENABLE_IN && PWRITE_IN
    && CE_IN |-> PREADY_OUT) else $error("write stalled");
  chk_err_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("error outside access cycle");
  chk_err_zero_data: assert property (PSLVERR_OUT && !PWRITE_IN
    |-> PRDATA_OUT == '0) else $error("unmapped read not zero");
  chk_byte_wide_data: assert property (PRDATA_OUT[31:8] == '0)
    else $error("upper read data not zero");
  chk_global_off: assert property (s_wr_done ##0 PADDR_IN == OFS_IRQ_ENABLE
    && !(PWDATA_IN[IE_GLOBAL] && PWDATA_IN[IE_ARRAY]) |=> !IRQ_OUT)
    else $error("interrupt with enables off");
  chk_mask_off: assert property (s_wr_done ##0 PADDR_IN == OFS_IRQ_MASK
    && PWDATA_IN[3:0] == 4'h0 |=> !IRQ_OUT) else $error("masked irq high");
  // the interrupt may only drop as a result of a completed bus access
  chk_irq_drop: assert property ($fell(IRQ_OUT) |-> $past(PREADY_OUT)
    && $past(PENABLE_IN)) else $error("interrupt dropped by itself");
  chk_reset_quiet: assert property ($rose(RST_B_IN) |-> !IRQ_OUT
    && MODULE_IO_OE_OUT == '0 && !WATCHDOG_RST_OUT)
    else $error("outputs active after reset");
endmodule
bind counter_array_timebase counter_array_timebase_properties chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT),
  .MODULE_IO_OE_OUT(MODULE_IO_OE_OUT), .WATCHDOG_RST_OUT(WATCHDOG_RST_OUT));
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, e, g) check(n, 32'(e), 32'(g))
module tb_top;
  import counter_array_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        idle = 1'b0;
  logic        t0_ovf = 1'b0;
  logic        ext_cnt = 1'b1;
  logic        xosc = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [2:0]  io_out;
  logic [2:0]  io_oe;
  logic [4:0]  ph = 5'h00;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // source periods: t0 every 8, ext fall every 16, xosc rise every 32
  int          div [6] = '{12, 4, 8, 16, 1, 32};
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  always @(posedge clk) begin
    ph <= ph + 5'h01;
    t0_ovf <= (ph[2:0] == 3'h7);
    ext_cnt <= ph[3];
    xosc <= ph[4];
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  counter_array_timebase dut (
    .SYS_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1), .IDLE_IN(idle),
    .T0_OVF_IN(t0_ovf), .EXT_COUNT_IN(ext_cnt), .XOSC_DIV8_IN(xosc),
    .MODULE_IO_IN(3'h0), .MODULE_IO_OUT(io_out), .MODULE_IO_OE_OUT(io_oe),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq),
    .WATCHDOG_RST_OUT());
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // settled values just before the edge equal those sampled at it
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setcnt(input logic [15:0] v);
    apb(1'b1, OFS_COUNT_HIGH, {24'h0, v[15:8]});
    apb(1'b1, OFS_COUNT_LOW, {24'h0, v[7:0]});
  endtask
  task automatic rdcnt(output logic [15:0] c);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    c[7:0] = rd[7:0];
    apb(1'b0, OFS_COUNT_HIGH, 32'h0);
    c[15:8] = rd[7:0];
  endtask
  function automatic logic [31:0] mode(input logic run, input logic [2:0] sel,
                                       input logic ie, input logic stp);
    return {24'h0, stp, 1'b0, run, 1'b0, sel, ie};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] c;
    logic [15:0] c2;
    int e;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, OFS_ARRAY_MODE, 32'h0);
    `CHECK("mode_reset", MODE_RESET, rd);
    apb(1'b1, OFS_ARRAY_MODE, 32'hAF);
    apb(1'b0, OFS_ARRAY_MODE, 32'h0);
    `CHECK("wd_protect", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0);
    `CHECK("unmapped_err", 1'b1, err);
    `CHECK("unmapped", 32'h0, rd);
    setcnt(16'h1234);
    rdcnt(c);
    `CHECK("count16", 16'h1234, c);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    apb(1'b1, OFS_COUNT_HIGH, 32'h56);
    apb(1'b0, OFS_COUNT_HIGH, 32'h0);
    `CHECK("snapshot", 32'h12, rd);
    rdcnt(c);
    `CHECK("relatch", 16'h5634, c);
    // the stop write is as long as the start write, so the window is 384
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_ARRAY_MODE, mode(1'b0, 3'(i), 1'b0, 1'b0));
      setcnt(16'h0000);
      apb(1'b1, OFS_ARRAY_MODE, mode(1'b1, 3'(i), 1'b0, 1'b0));
      repeat (381) @(posedge clk);
      apb(1'b1, OFS_ARRAY_MODE, mode(1'b0, 3'(i), 1'b0, 1'b0));
      rdcnt(c);
      e = 384 / div[i];
      `CHECK("rate", 1'b1, (c >= e - 2 && c <= e + 2));
    end
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b1, TB_SYS, 1'b0, 1'b0));
    idle <= 1'b1;
    rdcnt(c);
    rdcnt(c2);
    `CHECK("read_run", 16'd6, c2 - c);
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b1, TB_SYS, 1'b0, 1'b1));
    rdcnt(c);
    rdcnt(c2);
    `CHECK("idle_stop", c, c2);
    idle <= 1'b0;
    apb(1'b1, OFS_IRQ_ENABLE, 32'h81);
    apb(1'b1, OFS_IRQ_MASK, 32'h01);
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b0, TB_SYS, 1'b1, 1'b0));
    setcnt(16'hFFF0);
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b1, TB_SYS, 1'b1, 1'b0));
    repeat (30) @(posedge clk);
    @(negedge clk);
    `CHECK("irq_on", 1'b1, irq);
    apb(1'b0, OFS_ARRAY_MODE, 32'h0);
    `CHECK("flag_set", 1'b1, rd[MD_OVF_FLAG]);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h01);
    @(negedge clk);
    `CHECK("irq_global", 1'b0, irq);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h81);
    @(negedge clk);
    `CHECK("irq_back", 1'b1, irq);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    `CHECK("status", 1'b1, rd[ST_OVERFLOW]);
    @(negedge clk);
    `CHECK("irq_cleared", 1'b0, irq);
    apb(1'b0, OFS_ARRAY_MODE, 32'h0);
    `CHECK("flag_sticky", 1'b1, rd[MD_OVF_FLAG]);
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b0, TB_SYS, 1'b0, 1'b0));
    apb(1'b0, OFS_ARRAY_MODE, 32'h0);
    `CHECK("flag_clear", 1'b0, rd[MD_OVF_FLAG]);
    setcnt(16'hFFF0);
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b1, TB_SYS, 1'b0, 1'b0));
    repeat (30) @(posedge clk);
    @(negedge clk);
    `CHECK("irq_disabled", 1'b0, irq);
    apb(1'b0, OFS_ARRAY_MODE, 32'h0);
    `CHECK("flag_again", 1'b1, rd[MD_OVF_FLAG]);
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b1, TB_SYS, 1'b1, 1'b0));
    @(negedge clk);
    `CHECK("irq_enabled", 1'b1, irq);
    apb(1'b1, OFS_IRQ_MASK, 32'h00);
    @(negedge clk);
    `CHECK("irq_masked", 1'b0, irq);
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b0, TB_SYS, 1'b0, 1'b0));
    setcnt(16'h0000);
    apb(1'b1, {MOD_BASE_NIB, OFS_MOD_CMP_LO}, 32'h10);
    apb(1'b1, {MOD_BASE_NIB, OFS_MOD_CMP_HI}, 32'h00);
    apb(1'b1, {MOD_BASE_NIB, OFS_MOD_CTRL}, 32'h4C);
    @(negedge clk);
    `CHECK("io_oe", 3'h1, io_oe);
    apb(1'b1, OFS_ARRAY_MODE, mode(1'b1, TB_SYS, 1'b0, 1'b0));
    repeat (30) @(posedge clk);
    @(negedge clk);
    `CHECK("io_toggle", 3'h1, io_out);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
